// [verilog/mpr_map.svh]
`ifndef MPR_MAP_SVH
`define MPR_MAP_SVH
// Overview of operation
// R01: Transient detect with boost enabled turns on all active phases together.
// R02: Boost disabled means plain interleaved PWM, never simultaneous phase turn-on.
// R03: Phase strap floating runs phases one and three; grounded runs all three.
// R04: Straps are sampled once before start-up and held fixed afterwards.
// R05: Family strap shorted selects six-bit codes; resistor above 2.4 kOhm selects 7/8-bit.
// R06: The 7/8-bit family lowers the reference by 19 mV; six-bit has none.
// R07: 7/8-bit strap sets soft-start and gain, default 2; six-bit fixed, gain 2.
// R08: Over-voltage level is external, or 1.800 V fixed, or code plus 175 mV.
// R09: Over-voltage trip latches at once, turns all low sides on, raises fault.
// R10: Over-voltage protection stays active while supply is under lockout.
// R11: Over-current turns every high and low side switch off and latches; code clears drivers_off and turns low sides on once over-voltage latches.
// R12: Table strap open selects newer table, grounded the older; static only.
// R13: 7/8-bit family: open code input reads one, grounded reads zero.
// R14: Six-bit family: open code inputs read zero; board grounds bit six and table strap.
// R15: Six-bit family: top code pin drives high in transitions, plus 32 cycles.
// R16: 7/8-bit family: status output released when soft-start ends.
// R17: Six-bit family: status released after soft-start only inside regulation window.
// R18: Applied code picks the reference tap; code changes step as managed transitions.
// R19: Low sides are held off during soft-start over a pre-biased output.
// R20: Temperature comparators drive thermal warning and, higher, thermal alarm.
// R21: Latched faults clear only by reset or supply cycle; the code clears them only on hresetn, and a drop of supply_ok leaves them set.

// ----------------------------------------
// Register map
// ----------------------------------------
`define MPR_CTRL_OFS        8'h00
`define MPR_STATUS_OFS      8'h04
`define MPR_CODE_OFS        8'h08
`define MPR_CTRL_BOOST_BIT  0
`define MPR_CTRL_EXTOVP_BIT 1
`define MPR_CTRL_RST        2'h1

// ----------------------------------------
// Analog set-points and timing
// ----------------------------------------
`define MPR_REF_OFFSET_MV   5'h13
`define MPR_OVP_FIXED_MV    12'h708
`define MPR_OVP_MARGIN_MV   8'hAF
`define MPR_GAIN_DEFAULT    2'h2
`define MPR_CODE_TRANSITION_FLAG_HOLD_CYC   6'h20
`define MPR_STEP_CYC        2'h3
`endif

// [verilog/mpr_pkg.sv]
package mpr_pkg;

    typedef enum logic [1:0]
    {
        MPR_S_CFG   = 2'b00,
        MPR_S_SS    = 2'b01,
        MPR_S_RUN   = 2'b10,
        MPR_S_FAULT = 2'b11
    } mpr_state_t;

    // Pins from pads and analog comparators, all asynchronous
    typedef struct packed
    {
        logic       phase_strap_float;
        logic       family_strap_short;
        logic       table_strap_open;
        logic [2:0] softstart_res_code;
        logic [7:0] code_level;
        logic [7:0] code_open;
        logic       transient;
        logic       ov_cmp;
        logic       oc_cmp;
        logic       pg_window;
        logic       supply_ok;
        logic       output_enable_input;
        logic       therm_warn_cmp;
        logic       therm_alarm_cmp;
    } mpr_pin_t;

    typedef struct packed
    {
        logic [2:0] phase_en;
        logic       all_phase_on;
        logic       low_side_all_on;
        logic       drivers_off;
        logic       low_side_block;
        logic       fault;
        logic       status_oe_n;
        logic       therm_warn;
        logic       therm_alarm;
        logic       code7_out;
        logic       code7_oe_n;
        logic [4:0] ref_offset_mv;
        logic       ovp_external;
        logic       ovp_track_code;
        logic [1:0] boost_gain;
        logic [2:0] softstart_sel;
    } mpr_out_t;

    typedef struct packed
    {
        mpr_pin_t   s1;
        mpr_pin_t   s2;
        mpr_state_t fsm;
        logic       cfg_done;
        logic       three_phase;
        logic       fam78;
        logic       table_new;
        logic [2:0] ss_sel;
        logic       ov_lat;
        logic       oc_lat;
        logic [7:0] applied;
        logic [15:0] ss_cnt;
        logic [1:0] step_cnt;
        logic [5:0] hold_cnt;
        logic       in_step;
        logic [1:0] ctrl;
        logic       wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic       ready;
        mpr_out_t   out;
    } mpr_st_t;

endpackage

// [verilog/mpr_top.sv]
`timescale 1ns/1ns
`include "mpr_map.svh"

module mpr_top #(
    parameter logic [15:0] SS_BASE_CYC = 16'h03E8
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic [31:0]           hrdata,
    output logic                  hresp,
    input  wire mpr_pkg::mpr_pin_t pins,
    output mpr_pkg::mpr_out_t     drv
);

    mpr_pkg::mpr_st_t q;
    mpr_pkg::mpr_st_t d;

    logic [7:0]  target;
    logic        take;
    logic [15:0] ss_len;
    logic        pg_ok;

    // ----------------------------------------
    // Code input decode
    // ----------------------------------------
    always_comb
    begin
        target = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (q.fam78)
            begin
                target[i] = q.s2.code_open[i] ? 1'b1 : q.s2.code_level[i]; // R13
            end
            else if (i < 6)
            begin
                target[i] = q.s2.code_open[i] ? 1'b0 : q.s2.code_level[i]; // R14
            end
        end
    end

    assign take = hsel && htrans[1] && hready;
    // Strap scales soft-start only in the 7/8-bit family
    assign ss_len = q.fam78 ? 16'(SS_BASE_CYC * (16'(q.ss_sel) + 16'h0001))
                            : SS_BASE_CYC; // R07
    assign pg_ok = q.fam78 ? 1'b1 : q.s2.pg_window; // R16 R17

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;

        // Configuration capture, frozen once start-up begins
        if (!q.cfg_done)
        begin
            d.three_phase = !q.s2.phase_strap_float; // R03 R04
            d.fam78       = !q.s2.family_strap_short; // R05 R04
            d.table_new   = q.s2.table_strap_open; // R12
            d.ss_sel      = q.s2.softstart_res_code;
        end

        // Latches set only; no path clears them
        if (q.s2.ov_cmp)
        begin
            d.ov_lat = 1'b1; // R09 R10 R21
        end
        if (q.s2.oc_cmp && q.fsm != mpr_pkg::MPR_S_CFG)
        begin
            d.oc_lat = 1'b1; // R11 R21
        end

        unique case (q.fsm)
            mpr_pkg::MPR_S_CFG:
            begin
                d.ss_cnt = 16'h0000;
                if (q.s2.supply_ok && q.s2.output_enable_input)
                begin
                    d.cfg_done = 1'b1; // R04
                    d.applied  = target;
                    d.fsm      = mpr_pkg::MPR_S_SS;
                end
            end
            mpr_pkg::MPR_S_SS:
            begin
                d.ss_cnt = q.ss_cnt + 16'h0001;
                d.applied = target;
                if (q.ss_cnt >= ss_len - 16'h0001)
                begin
                    d.fsm = mpr_pkg::MPR_S_RUN;
                end
            end
            mpr_pkg::MPR_S_RUN:
            begin
                // Step one code at a time so the reference slews smoothly
                if (q.applied != target)
                begin
                    d.in_step  = 1'b1; // R18
                    d.step_cnt = q.step_cnt + 2'h1;
                    if (q.step_cnt == `MPR_STEP_CYC)
                    begin
                        d.step_cnt = 2'h0;
                        d.applied  = (target > q.applied) ? q.applied + 8'h01
                                                          : q.applied - 8'h01; // R18
                    end
                    d.hold_cnt = 6'h00;
                end
                else if (q.in_step)
                begin
                    d.hold_cnt = q.hold_cnt + 6'h01; // R15
                    if (q.hold_cnt == `MPR_CODE_TRANSITION_FLAG_HOLD_CYC - 6'h01)
                    begin
                        d.in_step  = 1'b0;
                        d.hold_cnt = 6'h00;
                    end
                end
            end
            mpr_pkg::MPR_S_FAULT:
            begin
                d.fsm = mpr_pkg::MPR_S_FAULT; // R21
            end
        endcase

        if (q.fsm != mpr_pkg::MPR_S_FAULT && (d.ov_lat || d.oc_lat))
        begin
            d.fsm = mpr_pkg::MPR_S_FAULT;
        end
        else if ((q.fsm == mpr_pkg::MPR_S_SS || q.fsm == mpr_pkg::MPR_S_RUN)
                 && !(q.s2.supply_ok && q.s2.output_enable_input))
        begin
            d.fsm     = mpr_pkg::MPR_S_CFG;
            d.in_step = 1'b0;
        end

        // ----------------------------------------
        // AHB-Lite slave
        // ----------------------------------------
        d.ready   = 1'b1;
        d.wr_pend = take && hwrite;
        if (take)
        begin
            d.wr_addr = haddr[7:0];
        end
        if (q.wr_pend && q.wr_addr == `MPR_CTRL_OFS)
        begin
            d.ctrl = hwdata[1:0];
        end
        if (take && !hwrite)
        begin
            unique case (haddr[7:0])
                `MPR_CTRL_OFS:
                begin
                    d.rdata = {30'h00000000, q.ctrl};
                end
                `MPR_STATUS_OFS:
                begin
                    d.rdata = {19'h00000, q.ss_sel, q.fsm, q.out.therm_alarm,
                               q.out.therm_warn, q.in_step, q.oc_lat, q.ov_lat,
                               q.table_new, q.fam78, q.three_phase};
                end
                `MPR_CODE_OFS:
                begin
                    d.rdata = {16'h0000, target, q.applied};
                end
                default:
                begin
                    d.rdata = 32'h00000000;
                end
            endcase
        end
        else
        begin
            d.rdata = 32'h00000000;
        end

        // ----------------------------------------
        // Drive outputs
        // ----------------------------------------
        d.out.phase_en = 3'h0;
        if (q.fsm == mpr_pkg::MPR_S_SS || q.fsm == mpr_pkg::MPR_S_RUN)
        begin
            d.out.phase_en = q.three_phase ? 3'h7 : 3'h5; // R03
        end
        // Boost off leaves interleaved timing untouched
        d.out.all_phase_on    = q.ctrl[`MPR_CTRL_BOOST_BIT] && q.s2.transient
                                && q.fsm == mpr_pkg::MPR_S_RUN; // R01 R02
        d.out.low_side_all_on = d.ov_lat; // R09 R10
        d.out.drivers_off     = d.oc_lat && !d.ov_lat; // R11
        d.out.low_side_block  = q.fsm == mpr_pkg::MPR_S_SS
                                || q.fsm == mpr_pkg::MPR_S_CFG; // R19
        d.out.fault           = d.ov_lat; // R09
        d.out.status_oe_n     = q.fsm == mpr_pkg::MPR_S_RUN && pg_ok; // R16 R17
        d.out.therm_warn      = q.s2.therm_warn_cmp || q.s2.therm_alarm_cmp; // R20
        d.out.therm_alarm     = q.s2.therm_alarm_cmp; // R20
        d.out.code7_oe_n      = q.fam78 || !q.cfg_done; // R15
        d.out.code7_out       = !q.fam78 && q.in_step; // R15
        d.out.ref_offset_mv   = q.fam78 ? `MPR_REF_OFFSET_MV : 5'h00; // R06
        d.out.ovp_external    = q.ctrl[`MPR_CTRL_EXTOVP_BIT]; // R08
        d.out.ovp_track_code  = q.fam78; // R08
        d.out.boost_gain      = (q.fam78 && q.ss_sel[1:0] != 2'h0) ? q.ss_sel[1:0]
                                                               : `MPR_GAIN_DEFAULT; // R07
        d.out.softstart_sel   = q.fam78 ? q.ss_sel : 3'h0; // R07
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.fsm <= mpr_pkg::MPR_S_CFG;
            q.ctrl <= `MPR_CTRL_RST;
            q.ready <= 1'b1;
            q.out.low_side_block <= 1'b1;
            q.out.status_oe_n <= 1'b0;
            q.out.code7_oe_n <= 1'b1;
            q.out.boost_gain <= `MPR_GAIN_DEFAULT;
        end
        else
        begin
            q <= d;
        end
    end

    assign hreadyout = q.ready;
    assign hrdata    = q.rdata;
    assign hresp     = 1'b0;
    assign drv       = q.out;

endmodule

// [dv/mpr_properties.sv]
`timescale 1ns/1ns
module mpr_properties (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire mpr_pkg::mpr_pin_t pins,
    input wire mpr_pkg::mpr_out_t drv
);
    // --------------------
    // Protection and mode
    // --------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ov_trip: assert property ($rose(pins.ov_cmp) |-> ##[1:4] drv.fault)
        else $error("ov trip late");
    a_ov_sides: assert property (drv.fault |-> drv.low_side_all_on && !drv.drivers_off)
        else $error("ov drive wrong");
    a_fault_kept: assert property (drv.fault |=> drv.fault)
        else $error("fault cleared");
    a_oc_trip: assert property (pins.oc_cmp && drv.phase_en[0] |-> ##[1:4] drv.drivers_off)
        else $error("oc trip late");
    a_phase_pair: assert property (drv.phase_en != 3'h0 |-> drv.phase_en[0] && drv.phase_en[2])
        else $error("bad phase set");
    a_boost_cause: assert property (drv.all_phase_on |-> $past(pins.transient, 3))
        else $error("boost without transient");
    a_ss_block: assert property ($rose(drv.phase_en[0]) |-> drv.low_side_block)
        else $error("low side free in start");
    a_family_link: assert property (drv.ovp_track_code == (drv.ref_offset_mv == 5'h13))
        else $error("offset and ovp mode differ");
    a_gain_fixed: assert property (!drv.ovp_track_code |-> drv.boost_gain == 2'h2)
        else $error("six-bit gain");
    a_flag_hold: assert property ($fell(drv.code7_out) |-> $past(drv.code7_out, 32))
        else $error("transition flag short");
    a_therm_order: assert property (drv.therm_alarm |-> drv.therm_warn)
        else $error("alarm without warn");
endmodule

bind mpr_top mpr_properties u_chk (.hclk(hclk), .hresetn(hresetn), .pins(pins), .drv(drv));

// [dv/mpr_host_model.sv]
`timescale 1ns/1ns
module mpr_host_model (
    input  wire logic       hclk,
    input  wire logic       six,
    input  wire logic [7:0] code,
    input  wire logic [7:0] dmask,
    output logic      [7:0] lvl,
    output logic      [7:0] opn
);
    // --------------------
    // Code pads
    // --------------------
    initial
    begin
        lvl = 8'h00;
        opn = 8'hFF;
    end
    // Open pad shows the level against its pull, so only the open flag reads right
    always @(posedge hclk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            opn[i] <= !dmask[i];
            lvl[i] <= dmask[i] ? code[i] : six;
        end
        if (six)
        begin
            opn[6] <= 1'b0;
            lvl[6] <= 1'b0;
            opn[7] <= 1'b1;
        end
    end
endmodule

// [dv/mpr_top_bench.sv]
`timescale 1ns/1ns
module mpr_top_bench;
    logic              hclk;
    logic              hresetn;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [31:0]       hwdata;
    logic              hreadyout;
    logic [31:0]       hrdata;
    logic              hresp;
    logic              six;
    logic [7:0]        code;
    logic [7:0]        dmask;
    logic [7:0]        lvl;
    logic [7:0]        opn;
    logic [31:0]       r;
    int                num_errors;
    int                tests_run;
    mpr_pkg::mpr_pin_t p;
    mpr_pkg::mpr_pin_t pins;
    mpr_pkg::mpr_out_t drv;

    // --------------------
    // Harness
    // --------------------
    always_comb
    begin
        pins            = p;
        pins.code_level = lvl;
        pins.code_open  = opn;
    end
    mpr_top #(.SS_BASE_CYC(16'h000A)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .pins(pins), .drv(drv));
    mpr_host_model host (.hclk(hclk), .six(six), .code(code), .dmask(dmask),
        .lvl(lvl), .opn(opn));
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic start(input logic ph, fs, tb, sup, input logic [2:0] ss);
        mpr_pkg::mpr_pin_t v;
        v = '0;
        v.phase_strap_float  = ph;
        v.family_strap_short = fs;
        v.table_strap_open   = tb;
        v.softstart_res_code = ss;
        @(posedge hclk);
        hresetn <= 1'b0;
        p       <= v;
        six     <= fs;
        dmask   <= 8'h00;
        repeat (10) @(posedge hclk);
        hresetn     <= 1'b1;
        v.supply_ok = sup;
        v.output_enable_input     = sup;
        v.pg_window = sup;
        p           <= v;
        repeat (8) @(posedge hclk);
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_lockout();
        start(1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
        p.therm_warn_cmp <= 1'b1;
        repeat (5) @(posedge hclk);
        chk("warn", {drv.therm_alarm, drv.therm_warn}, 2'h1);
        p.therm_alarm_cmp <= 1'b1;
        repeat (5) @(posedge hclk);
        chk("alarm", {drv.therm_alarm, drv.therm_warn}, 2'h3);
        p.ov_cmp <= 1'b1;
        repeat (5) @(posedge hclk);
        p.ov_cmp <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("pre_ov", {drv.fault, drv.low_side_all_on}, 2'h3);
    endtask
    task automatic t_six();
        int i;
        start(1'b1, 1'b1, 1'b0, 1'b1, 3'h0);
        chk("fault_clr", drv.fault, 1'b0);
        chk("phases", drv.phase_en, 3'h5);
        chk("mode", {drv.ref_offset_mv, drv.ovp_track_code, drv.boost_gain}, 8'h02);
        repeat (20) @(posedge hclk);
        chk("pgood", drv.status_oe_n, 1'b1);
        p.pg_window <= 1'b0;
        @(posedge hclk);
        p.phase_strap_float <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("pgood_lost", drv.status_oe_n, 1'b0);
        chk("phases_kept", drv.phase_en, 3'h5);
        code  <= 8'h05;
        dmask <= 8'h07;
        repeat (6) @(posedge hclk);
        chk("flag_on", {drv.code7_out, drv.code7_oe_n}, 2'h2);
        for (i = 0; i < 200 && drv.code7_out !== 1'b0; i++) @(posedge hclk);
        // Five code steps of four cycles, then the 32-cycle hold
        chk("flag_off", drv.code7_out, 1'b0);
        chk("flag_len", i, 32'd51);
        bus(1'b0, 32'h8, 32'h0);
        chk("code", r & 32'h3F3F, 32'h0505);
        bus(1'b0, 32'h4, 32'h0);
        chk("status", r & 32'h3, 32'h0);
        p.output_enable_input <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("lockout", {drv.phase_en, drv.low_side_block}, 4'h1);
    endtask
    task automatic t_fam78();
        start(1'b0, 1'b0, 1'b1, 1'b1, 3'h4);
        dmask <= 8'h01;
        code  <= 8'h00;
        chk("phases", drv.phase_en, 3'h7);
        chk("mode", {drv.ref_offset_mv, drv.ovp_track_code}, 6'h27);
        chk("ss_gain", {drv.softstart_sel, drv.boost_gain}, 5'h12);
        chk("ss_busy", {drv.status_oe_n, drv.low_side_block}, 2'h1);
        p.pg_window <= 1'b0;
        repeat (60) @(posedge hclk);
        chk("ss_end", {drv.status_oe_n, drv.low_side_block}, 2'h2);
        bus(1'b0, 32'h4, 32'h0);
        chk("status", r & 32'h7, 32'h7);
        bus(1'b0, 32'h8, 32'h0);
        chk("target", r[15:8], 8'hFE);
        bus(1'b0, 32'h0, 32'h0);
        chk("ctrl_rst", r, 32'h1);
        bus(1'b0, 32'hC, 32'h0);
        chk("unmapped", r, 32'h0);
        chk("okay", hresp, 1'b0);
        bus(1'b1, 32'h0, 32'h2);
        p.transient <= 1'b1;
        repeat (5) @(posedge hclk);
        chk("no_boost", {drv.all_phase_on, drv.ovp_external}, 2'h1);
        bus(1'b1, 32'h0, 32'h1);
        repeat (5) @(posedge hclk);
        chk("boost", drv.all_phase_on, 1'b1);
        p.transient <= 1'b0;
        @(posedge hclk);
        p.oc_cmp <= 1'b1;
        repeat (5) @(posedge hclk);
        p.oc_cmp <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("oc_latch", {drv.drivers_off, drv.phase_en}, 4'h8);
        p.ov_cmp <= 1'b1;
        repeat (5) @(posedge hclk);
        chk("ov_latch", {drv.fault, drv.low_side_all_on, drv.drivers_off}, 3'h6);
    endtask
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Whole run is near 280 cycles; the limit of 10000 cycles leaves wide margin
    initial
    begin
        #400000;
        num_errors++;
        summarize();
    end
    initial
    begin
        hresetn    = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hwdata     = 32'h0;
        p          = '0;
        six        = 1'b1;
        code       = 8'h00;
        dmask      = 8'h00;
        num_errors = 0;
        tests_run  = 0;
        t_lockout();
        t_six();
        t_fam78();
        summarize();
    end
endmodule
